// ### hw/lps_serializer.sv
// Pixel word capture, power-down control and seven-slot lane serializer
`timescale 1ns/100ps
`include "lps_cfg.svh"

module lps_serializer #(
	parameter int LOCK_CYCLES = `LPS_PLL_LOCK_CYCLES
) (
	input  wire logic       CLOCK_I,
	input  wire logic       RESET_I,
	input  wire logic       LINK_CLK_I,
	input  wire logic       PIXEL_CLK_I,
	input  wire logic [5:0] RED_I,
	input  wire logic [5:0] GREEN_I,
	input  wire logic [5:0] BLUE_I,
	input  wire logic       LINE_SYNC_I,
	input  wire logic       FRAME_SYNC_I,
	input  wire logic       PIXEL_VALID_I,
	input  wire logic       STROBE_EDGE_SELECT_I,
	input  wire logic       POWER_DOWN_N_I,
	output logic [2:0]      LANE_DATA_P_O,
	output logic [2:0]      LANE_DATA_N_O,
	output logic [2:0]      LANE_DATA_OE_O,
	output logic            LANE_CLK_P_O,
	output logic            LANE_CLK_N_O,
	output logic            LANE_CLK_OE_O,
	output logic            LOCKED_O,
	output logic            FIFO_READY_O,
	output logic            OVERFLOW_O
);

	// ------------------------------------------------------------------
	// Declarations, pixel side
	// ------------------------------------------------------------------
	localparam logic [16:0] LOCK_LAST = 17'(LOCK_CYCLES - 1);

	lps_pkg::lps_word_t  pin_word;           // Pins gathered into one word
	lps_pkg::lps_word_t  data_s1_q;          // Data synchroniser, stage 1
	lps_pkg::lps_word_t  data_s2_q;          // Data synchroniser, stage 2
	lps_pkg::lps_word_t  word_q;             // Captured pixel word
	lps_pkg::lps_state_e state_q;            // Power state
	lps_pkg::lps_state_e state_d;
	logic [2:0]          pclk_sync_q;        // Pixel clock synchroniser plus history
	logic [1:0]          sel_sync_q;         // Edge select synchroniser
	logic [1:0]          pdn_sync_q;         // Power-down synchroniser, pixel side
	logic [16:0]         lock_cnt_q;         // Lock settling counter
	logic                word_vld_q;         // Captured word waiting for the FIFO
	logic                strobe;             // Selected pixel clock edge seen
	logic                standby;            // Power-down held
	logic                run_q;              // Pixel side running, crosses as a level
	logic                fifo_wr_ready;
	logic                fifo_clr;

	// ------------------------------------------------------------------
	// Declarations, link side
	// ------------------------------------------------------------------
	lps_pkg::lps_word_t  lane_word_q;        // Word being shifted onto lanes
	lps_pkg::lps_word_t  fifo_rd_data;
	logic [1:0]          link_rst_q;         // Link reset synchroniser
	logic [1:0]          run_sync_q;         // Run level in link domain
	logic [1:0]          pdn_link_q;         // Power-down straight into link domain
	logic [2:0]          slot_q;             // Current bit slot, 0 to 6
	logic [2:0]          slot_d;
	logic                link_rst;
	logic                link_on;            // Lanes may drive
	logic                frame_end;          // Last slot of a period
	logic                fifo_rd_valid;
	logic                fifo_rd_ready;

	// Bit of a word assigned to a lane and slot
	function automatic logic lane_bit(input lps_pkg::lps_word_t w, input logic [1:0] lane,
		input logic [2:0] slot);
		logic [4:0] idx;
		idx = 5'(lane * `LPS_SLOTS) + 5'(slot);
		lane_bit = w[idx];
	endfunction

	// ------------------------------------------------------------------
	// Pixel side: pin synchronisers
	// ------------------------------------------------------------------
	// Pack colour and control pins
	assign pin_word = {PIXEL_VALID_I, FRAME_SYNC_I, LINE_SYNC_I, BLUE_I, GREEN_I, RED_I};

	// Two flops on every pin before use
	always_ff @(posedge CLOCK_I or posedge RESET_I) begin
		if (RESET_I) begin
			data_s1_q   <= `LPS_IDLE_WORD;
			data_s2_q   <= `LPS_IDLE_WORD;
			pclk_sync_q <= 3'h0;
			sel_sync_q  <= 2'h0;
			pdn_sync_q  <= 2'h0;
		end else begin
			data_s1_q   <= pin_word;
			data_s2_q   <= data_s1_q;
			pclk_sync_q <= {pclk_sync_q[1:0], PIXEL_CLK_I};
			sel_sync_q  <= {sel_sync_q[0], STROBE_EDGE_SELECT_I};
			pdn_sync_q  <= {pdn_sync_q[0], POWER_DOWN_N_I};
		end
	end

	assign standby = ~pdn_sync_q[1];

	assign strobe = sel_sync_q[1] ? (pclk_sync_q[1] & ~pclk_sync_q[2])
	                              : (~pclk_sync_q[1] & pclk_sync_q[2]);

	// ------------------------------------------------------------------
	// Pixel side: power state
	// ------------------------------------------------------------------
	// Next state; standby wins from any state
	always_comb begin
		state_d = state_q;
		case (state_q)
			lps_pkg::LPS_ST_STANDBY: begin
				if (!standby) begin
					state_d = lps_pkg::LPS_ST_LOCKING;
				end
			end
			lps_pkg::LPS_ST_LOCKING: begin
				if (standby) begin
					state_d = lps_pkg::LPS_ST_STANDBY;
				end else if (lock_cnt_q == LOCK_LAST) begin
					state_d = lps_pkg::LPS_ST_RUN;
				end
			end
			lps_pkg::LPS_ST_RUN: begin
				if (standby) begin
					state_d = lps_pkg::LPS_ST_STANDBY;
				end
			end
			default: begin
				state_d = lps_pkg::LPS_ST_STANDBY;
			end
		endcase
	end

	// State register
	always_ff @(posedge CLOCK_I or posedge RESET_I) begin
		if (RESET_I) begin
			state_q <= lps_pkg::LPS_ST_STANDBY;
		end else begin
			state_q <= state_d;
		end
	end

	// Lock counter; stands at zero outside locking, which models the PLL held off
	always_ff @(posedge CLOCK_I or posedge RESET_I) begin
		if (RESET_I) begin
			lock_cnt_q <= 17'h00000;
		end else if (state_q != lps_pkg::LPS_ST_LOCKING) begin
			lock_cnt_q <= 17'h00000;
		end else if (lock_cnt_q != LOCK_LAST) begin
			lock_cnt_q <= lock_cnt_q + 17'h00001;
		end
	end

	// Run level and lock flag
	always_ff @(posedge CLOCK_I or posedge RESET_I) begin
		if (RESET_I) begin
			run_q    <= 1'b0;
			LOCKED_O <= 1'b0;
		end else begin
			run_q    <= (state_d == lps_pkg::LPS_ST_RUN);
			LOCKED_O <= (state_d == lps_pkg::LPS_ST_RUN);
		end
	end

	// ------------------------------------------------------------------
	// Pixel side: capture and FIFO feed
	// ------------------------------------------------------------------
	// capture word on strobe
	// no edges, no words; restart needs nothing
	always_ff @(posedge CLOCK_I or posedge RESET_I) begin
		if (RESET_I) begin
			word_q     <= `LPS_IDLE_WORD;
			word_vld_q <= 1'b0;
		end else if (!run_q) begin
			word_vld_q <= 1'b0;
		end else if (strobe) begin
			word_q     <= data_s2_q;
			word_vld_q <= 1'b1;
		end else if (fifo_wr_ready) begin
			word_vld_q <= 1'b0;
		end
	end

	// Overrun: a new strobe while the held word is still refused
	always_ff @(posedge CLOCK_I or posedge RESET_I) begin
		if (RESET_I) begin
			OVERFLOW_O   <= 1'b0;
			FIFO_READY_O <= 1'b0;
		end else begin
			OVERFLOW_O   <= run_q & strobe & word_vld_q & ~fifo_wr_ready;
			FIFO_READY_O <= fifo_wr_ready;
		end
	end

	// FIFO flushed whenever the pixel side is not running
	assign fifo_clr = ~run_q;

	// ------------------------------------------------------------------
	// Domain crossing buffer
	// ------------------------------------------------------------------
	// FIFO absorbs clock spread
	lps_fifo #(
		.WIDTH (`LPS_WORD_W),
		.DEPTH (`LPS_FIFO_DEPTH)
	) u_fifo (
		.wr_clk_i   (CLOCK_I),
		.wr_rst_i   (RESET_I),
		.wr_clr_i   (fifo_clr),
		.wr_valid_i (word_vld_q),
		.wr_ready_o (fifo_wr_ready),
		.wr_data_i  (word_q),
		.rd_clk_i   (LINK_CLK_I),
		.rd_rst_i   (link_rst),
		.rd_clr_i   (~link_on),
		.rd_valid_o (fifo_rd_valid),
		.rd_ready_i (fifo_rd_ready),
		.rd_data_o  (fifo_rd_data)
	);

	// ------------------------------------------------------------------
	// Link side: reset and level crossings
	// ------------------------------------------------------------------
	// Reset asserts at once, releases on the link clock
	always_ff @(posedge LINK_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			link_rst_q <= 2'h3;
		end else begin
			link_rst_q <= {link_rst_q[0], 1'b0};
		end
	end

	assign link_rst = link_rst_q[1];

	// direct power-down path, two link cycles
	always_ff @(posedge LINK_CLK_I or posedge link_rst) begin
		if (link_rst) begin
			pdn_link_q <= 2'h0;
			run_sync_q <= 2'h0;
		end else begin
			pdn_link_q <= {pdn_link_q[0], POWER_DOWN_N_I};
			run_sync_q <= {run_sync_q[0], run_q};
		end
	end

	assign link_on = pdn_link_q[1] & run_sync_q[1];

	// ------------------------------------------------------------------
	// Link side: slot sequencer
	// ------------------------------------------------------------------
	assign frame_end     = (slot_q == `LPS_SLOT_LAST);
	assign fifo_rd_ready = link_on & frame_end;
	assign slot_d        = frame_end ? 3'h0 : slot_q + 3'h1;

	always_ff @(posedge LINK_CLK_I or posedge link_rst) begin
		if (link_rst) begin
			slot_q <= `LPS_SLOT_LAST;
		end else if (!link_on) begin
			slot_q <= `LPS_SLOT_LAST;
		end else begin
			slot_q <= slot_d;
		end
	end

	// Next word at the period boundary; idle word keeps the clock lane going
	always_ff @(posedge LINK_CLK_I or posedge link_rst) begin
		if (link_rst) begin
			lane_word_q <= `LPS_IDLE_WORD;
		end else if (!link_on) begin
			lane_word_q <= `LPS_IDLE_WORD;
		end else if (frame_end) begin
			lane_word_q <= fifo_rd_valid ? fifo_rd_data : `LPS_IDLE_WORD;
		end
	end

	// ------------------------------------------------------------------
	// Link side: lane drivers
	// ------------------------------------------------------------------
	// Data lanes; pins low while disabled so a floating net is never driven
	always_ff @(posedge LINK_CLK_I or posedge link_rst) begin
		if (link_rst) begin
			LANE_DATA_P_O  <= 3'h0;
			LANE_DATA_N_O  <= 3'h0;
			LANE_DATA_OE_O <= 3'h0;
		end else begin
			for (int l = 0; l < `LPS_LANES; l++) begin
				LANE_DATA_P_O[l]  <= link_on & lane_bit(lane_word_q, 2'(l), slot_q);
				LANE_DATA_N_O[l]  <= link_on & ~lane_bit(lane_word_q, 2'(l), slot_q);
				LANE_DATA_OE_O[l] <= link_on;
			end
		end
	end

	// Forwarded clock lane
	always_ff @(posedge LINK_CLK_I or posedge link_rst) begin
		if (link_rst) begin
			LANE_CLK_P_O  <= 1'b0;
			LANE_CLK_N_O  <= 1'b0;
			LANE_CLK_OE_O <= 1'b0;
		end else begin
			LANE_CLK_P_O  <= link_on & (slot_q < `LPS_CLK_HIGH_SLOTS);
			LANE_CLK_N_O  <= link_on & (slot_q >= `LPS_CLK_HIGH_SLOTS);
			LANE_CLK_OE_O <= link_on;
		end
	end

endmodule // lps_serializer

// ### hw/lps_cfg.svh
// Constants for the pixel serializer: lane layout, timing figures and cycle counts
`ifndef LPS_CFG_SVH
`define LPS_CFG_SVH

// ------------------------------------------------------------------
// Word and lane layout
// ------------------------------------------------------------------
`define LPS_WORD_W            21
`define LPS_COLOUR_W          6
`define LPS_LANES             3
`define LPS_SLOTS             7
`define LPS_SLOT_LAST         3'h6
`define LPS_CLK_HIGH_SLOTS    3'h4
`define LPS_RED_LSB           0
`define LPS_GREEN_LSB         6
`define LPS_BLUE_LSB          12
`define LPS_LINE_BIT          18
`define LPS_FRAME_BIT         19
`define LPS_VALID_BIT         20
`define LPS_IDLE_WORD         21'h000000

// ------------------------------------------------------------------
// Timing figures
// ------------------------------------------------------------------
`define LPS_CLOCK_PERIOD_NS   100
`define LPS_PLL_LOCK_TIME_MS  10
`define LPS_OUTPUT_DISABLE_NS 100
`define LPS_LINK_PERIOD_NS    15
`define LPS_STANDBY_MIN_US    1
// Lock window less 8 cycles, so the sync and crossing delay still fit the bound
`define LPS_PLL_LOCK_CYCLES   (((`LPS_PLL_LOCK_TIME_MS * 1000000) / `LPS_CLOCK_PERIOD_NS) - 8)
// Longest time in link cycles: round down
`define LPS_DISABLE_LINK_CYC  (`LPS_OUTPUT_DISABLE_NS / `LPS_LINK_PERIOD_NS)

// ------------------------------------------------------------------
// FIFO
// ------------------------------------------------------------------
`define LPS_FIFO_DEPTH        4

`endif

// ### hw/lps_pkg.sv
// Types shared by the pixel serializer files
package lps_pkg;

	// ------------------------------------------------------------------
	// Power state, Gray coded along standby -> locking -> run
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		LPS_ST_STANDBY = 2'b00,
		LPS_ST_LOCKING = 2'b01,
		LPS_ST_RUN     = 2'b11
	} lps_state_e;

	// One parallel pixel word
	typedef logic [20:0] lps_word_t;

endpackage

// ### hw/lps_fifo.sv
// Dual-clock FIFO with Gray-coded pointers between pixel and link domains
`timescale 1ns/100ps

module lps_fifo #(
	parameter int WIDTH = 21,
	parameter int DEPTH = 4
) (
	input  wire logic             wr_clk_i,
	input  wire logic             wr_rst_i,
	input  wire logic             wr_clr_i,
	input  wire logic             wr_valid_i,
	output logic                  wr_ready_o,
	input  wire logic [WIDTH-1:0] wr_data_i,
	input  wire logic             rd_clk_i,
	input  wire logic             rd_rst_i,
	input  wire logic             rd_clr_i,
	output logic                  rd_valid_o,
	input  wire logic             rd_ready_i,
	output logic [WIDTH-1:0]      rd_data_o
);

	// ------------------------------------------------------------------
	// Storage and pointers
	// ------------------------------------------------------------------
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];   // Word storage
	logic [AW:0]      wr_bin_q;        // Write pointer, binary
	logic [AW:0]      wr_gray_q;       // Write pointer, Gray
	logic [AW:0]      rd_bin_q;        // Read pointer, binary
	logic [AW:0]      rd_gray_q;       // Read pointer, Gray
	logic [AW:0]      rg_s1_q;         // Read pointer in write domain, stage 1
	logic [AW:0]      rg_s2_q;         // Read pointer in write domain, stage 2
	logic [AW:0]      wg_s1_q;         // Write pointer in read domain, stage 1
	logic [AW:0]      wg_s2_q;         // Write pointer in read domain, stage 2
	logic [AW:0]      wr_bin_d;
	logic [AW:0]      rd_bin_d;
	logic             push;
	logic             pop;

	// Binary to Gray, used for both pointers
	function automatic logic [AW:0] to_gray(input logic [AW:0] b);
		to_gray = b ^ (b >> 1);
	endfunction

	// Full when write Gray equals read Gray with two top bits inverted
	assign wr_ready_o = (wr_gray_q != {~rg_s2_q[AW:AW-1], rg_s2_q[AW-2:0]});
	assign rd_valid_o = (rd_gray_q != wg_s2_q);
	assign rd_data_o  = mem_q[rd_bin_q[AW-1:0]];
	assign push       = wr_valid_i & wr_ready_o;
	assign pop        = rd_valid_o & rd_ready_i;
	assign wr_bin_d   = wr_bin_q + (AW+1)'(1);
	assign rd_bin_d   = rd_bin_q + (AW+1)'(1);

	// ------------------------------------------------------------------
	// Write domain
	// ------------------------------------------------------------------
	// Storage write, no reset needed on data
	always_ff @(posedge wr_clk_i) begin
		if (push) begin
			mem_q[wr_bin_q[AW-1:0]] <= wr_data_i;
		end
	end

	// Write pointer; clear flushes during standby
	always_ff @(posedge wr_clk_i or posedge wr_rst_i) begin
		if (wr_rst_i) begin
			wr_bin_q  <= '0;
			wr_gray_q <= '0;
		end else if (wr_clr_i) begin
			wr_bin_q  <= '0;
			wr_gray_q <= '0;
		end else if (push) begin
			wr_bin_q  <= wr_bin_d;
			wr_gray_q <= to_gray(wr_bin_d);
		end
	end

	// Read pointer crossing into write domain
	always_ff @(posedge wr_clk_i or posedge wr_rst_i) begin
		if (wr_rst_i) begin
			rg_s1_q <= '0;
			rg_s2_q <= '0;
		end else begin
			rg_s1_q <= rd_gray_q;
			rg_s2_q <= rg_s1_q;
		end
	end

	// ------------------------------------------------------------------
	// Read domain
	// ------------------------------------------------------------------
	// Read pointer; both sides clear during standby, so pointers meet at zero
	always_ff @(posedge rd_clk_i or posedge rd_rst_i) begin
		if (rd_rst_i) begin
			rd_bin_q  <= '0;
			rd_gray_q <= '0;
		end else if (rd_clr_i) begin
			rd_bin_q  <= '0;
			rd_gray_q <= '0;
		end else if (pop) begin
			rd_bin_q  <= rd_bin_d;
			rd_gray_q <= to_gray(rd_bin_d);
		end
	end

	// Write pointer crossing into read domain
	always_ff @(posedge rd_clk_i or posedge rd_rst_i) begin
		if (rd_rst_i) begin
			wg_s1_q <= '0;
			wg_s2_q <= '0;
		end else begin
			wg_s1_q <= wr_gray_q;
			wg_s2_q <= wg_s1_q;
		end
	end

endmodule // lps_fifo

// ### sim/lps_serializer_monitor.sv
// Concurrent checks on the pixel serializer top ports
`timescale 1ns/100ps

module lps_serializer_monitor #(
	parameter int LOCK_CYCLES = 20
) (
	input wire logic       CLOCK_I,
	input wire logic       RESET_I,
	input wire logic       LINK_CLK_I,
	input wire logic       POWER_DOWN_N_I,
	input wire logic [2:0] LANE_DATA_P_O,
	input wire logic [2:0] LANE_DATA_N_O,
	input wire logic [2:0] LANE_DATA_OE_O,
	input wire logic       LANE_CLK_P_O,
	input wire logic       LANE_CLK_N_O,
	input wire logic       LANE_CLK_OE_O,
	input wire logic       LOCKED_O,
	input wire logic       OVERFLOW_O
);
	// ----------
	// Awake counter
	// ----------
	// Cycles since power-down release, saturating so it never wraps
	int awake_cnt_q;
	always_ff @(posedge CLOCK_I or posedge RESET_I) begin
		if (RESET_I)
			awake_cnt_q <= 0;
		else if (!POWER_DOWN_N_I)
			awake_cnt_q <= 0;
		else if (awake_cnt_q < 1000000)
			awake_cnt_q <= awake_cnt_q + 1;
	end

	// ----------
	// Link side
	// ----------
	AST_OE_OFF: assert property (@(posedge LINK_CLK_I) disable iff (RESET_I)
		$fell(POWER_DOWN_N_I) |-> ##[0:5] (!LANE_CLK_OE_O && LANE_DATA_OE_O == 3'h0))
		else $error("outputs still driven after power-down");
	AST_IDLE_LOW: assert property (@(posedge LINK_CLK_I) disable iff (RESET_I)
		!LANE_CLK_OE_O |-> (!LANE_CLK_P_O && !LANE_CLK_N_O && LANE_DATA_P_O == 3'h0 && LANE_DATA_N_O == 3'h0))
		else $error("undriven lane not quiet");
	AST_OE_GROUP: assert property (@(posedge LINK_CLK_I) disable iff (RESET_I)
		LANE_DATA_OE_O == {3{LANE_CLK_OE_O}})
		else $error("lane enables disagree");
	AST_DIFF: assert property (@(posedge LINK_CLK_I) disable iff (RESET_I)
		LANE_CLK_OE_O |-> (LANE_CLK_N_O == ~LANE_CLK_P_O && LANE_DATA_N_O == ~LANE_DATA_P_O))
		else $error("pair halves not complementary");
	AST_CLK_FRAME: assert property (@(posedge LINK_CLK_I) disable iff (RESET_I || !POWER_DOWN_N_I)
		($rose(LANE_CLK_P_O) && LANE_CLK_OE_O) |-> LANE_CLK_P_O [*4] ##1 !LANE_CLK_P_O [*3] ##1 LANE_CLK_P_O)
		else $error("clock lane not four high three low");

	// ----------
	// Pixel side
	// ----------
	AST_LOCK_MIN: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		$rose(LOCKED_O) |-> awake_cnt_q >= LOCK_CYCLES)
		else $error("locked too early");
	AST_LOCK_MAX: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		awake_cnt_q == LOCK_CYCLES + 8 |-> LOCKED_O)
		else $error("lock late");
	AST_UNLOCK: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		!POWER_DOWN_N_I [*5] |-> !LOCKED_O)
		else $error("still locked in power-down");
	AST_OVF_PULSE: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		OVERFLOW_O |=> !OVERFLOW_O)
		else $error("overflow pulse too long");
endmodule // lps_serializer_monitor

// ### sim/lps_rx_model.sv
// Panel-side receiver model: rebuilds pixel words from the lanes
`timescale 1ns/100ps

module lps_rx_model (
	input wire logic       link_clk_i,
	input wire logic [2:0] data_p_i,
	input wire logic       clk_p_i,
	input wire logic       clk_oe_i
);
	lps_pkg::lps_word_t rx_q[$]; // Words with pixel_valid set
	lps_pkg::lps_word_t acc_q;   // Word being assembled
	logic [2:0]         slot_q;  // Current slot
	logic               prev_q;  // Clock lane last slot

	// Deserialize: rising clock lane marks slot 0
	always @(posedge link_clk_i) begin : rx_shift
		logic [2:0] s;
		s = (clk_p_i && !prev_q) ? 3'h0 : slot_q + 3'h1;
		for (int l = 0; l < 3; l++)
			acc_q[l * 7 + s] = data_p_i[l];
		// Idle words are dropped, so only real pixels queue
		if (s == 3'h6 && clk_oe_i && acc_q[20])
			rx_q.push_back(acc_q);
		slot_q = s;
		prev_q = clk_p_i;
	end
endmodule // lps_rx_model

// ### sim/testbench.sv
// Testbench for the pixel serializer
`timescale 1ns/100ps

module testbench;
	localparam int LOCK_CYCLES = 20; // Shortened lock count
	logic clock = 0, reset = 1, link_clk = 0, pix_clk = 0;
	logic link_run = 1, ovf_seen = 0; // Link clock gate, overflow pulse latch
	logic [5:0] red = 0, green = 0, blue = 0;
	logic line_s = 0, frame_s = 0, valid_s = 0, edge_sel = 0, pd_n = 1;
	logic [2:0] lane_p, lane_n, lane_oe;
	logic clk_p, clk_n, clk_oe, locked, fifo_rdy, ovf;
	int miscompares = 0, samples_checked = 0, cyc = 0;
	// Patterns that touch every colour and control bit
	lps_pkg::lps_word_t words[4] = '{21'h155555, 21'h1AAAAA, 21'h100001, 21'h1FFFFE};

	// ----------
	// Clocks and timeout
	// ----------
	initial forever #50 clock = ~clock;
	initial begin
		#3.7;
		// Gate low stalls the read side so the FIFO can fill
		forever #7.5 link_clk = ~link_clk & link_run;
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			final_report();
		end
	end
	// Overflow pulse latched away from the edge that launches it
	always @(negedge clock) begin
		if (ovf === 1'b1)
			ovf_seen <= 1'b1;
	end

	lps_serializer #(.LOCK_CYCLES(LOCK_CYCLES)) uut (.CLOCK_I(clock), .RESET_I(reset),
		.LINK_CLK_I(link_clk), .PIXEL_CLK_I(pix_clk), .RED_I(red), .GREEN_I(green), .BLUE_I(blue),
		.LINE_SYNC_I(line_s), .FRAME_SYNC_I(frame_s), .PIXEL_VALID_I(valid_s),
		.STROBE_EDGE_SELECT_I(edge_sel), .POWER_DOWN_N_I(pd_n), .LANE_DATA_P_O(lane_p),
		.LANE_DATA_N_O(lane_n), .LANE_DATA_OE_O(lane_oe), .LANE_CLK_P_O(clk_p), .LANE_CLK_N_O(clk_n),
		.LANE_CLK_OE_O(clk_oe), .LOCKED_O(locked), .FIFO_READY_O(fifo_rdy), .OVERFLOW_O(ovf));
	lps_rx_model rx (.link_clk_i(link_clk), .data_p_i(lane_p), .clk_p_i(clk_p), .clk_oe_i(clk_oe));

	// ----------
	// Tasks
	// ----------
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One pixel period: word a around the rise, word b around the fall
	// period scaled to the 100 ns sampler
	task automatic pix_cycle(input lps_pkg::lps_word_t wa, input lps_pkg::lps_word_t wb);
		put(wa);
		tick(6);
		pix_clk <= 1'b1;
		tick(6);
		put(wb);
		tick(6);
		pix_clk <= 1'b0;
		tick(6);
	endtask
	task automatic put(input lps_pkg::lps_word_t w);
		{valid_s, frame_s, line_s, blue, green, red} <= w;
	endtask
	task automatic expect_word(input lps_pkg::lps_word_t exp);
		int n = 0;
		while (rx.rx_q.size() == 0 && n < 100) begin
			tick(1);
			n++;
		end
		if (rx.rx_q.size() == 0)
			check("rx word", {11'h0, exp}, 32'hFFFFFFFF);
		else
			check("rx word", {11'h0, exp}, {11'h0, rx.rx_q.pop_front()});
	endtask
	// Bounded wait for the lock flag
	task automatic wait_lock();
		int n = 0;
		while (locked !== 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
		check("locked", 32'h1, {31'h0, locked});
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ----------
	// Main sequence
	// ----------
	initial begin
		tick(4);
		reset <= 1'b0;
		tick(10);
		check("locked early", 32'h0, {31'h0, locked});
		wait_lock();
		check("fifo ready", 32'h1, {31'h0, fifo_rdy});
		// Default falling strobe: only the late word must arrive
		foreach (words[i]) begin
			pix_cycle(words[i] ^ 21'h0FFFFF, words[i]);
			expect_word(words[i]);
		end
		edge_sel <= 1'b1;
		tick(2);
		foreach (words[i]) begin
			pix_cycle(words[i], words[i] ^ 21'h0FFFFF);
			expect_word(words[i]);
		end
		// Pixel clock stops, then restarts without power-down
		tick(200);
		check("idle rx", 32'h0, rx.rx_q.size());
		pix_cycle(words[1], words[1] ^ 21'h0FFFFF);
		expect_word(words[1]);
		// Link stalled: FIFO fills, one word held, sixth strobe overflows
		link_run <= 1'b0;
		for (int i = 0; i < 6; i++)
			pix_cycle(words[i < 4 ? i : 0], 21'h0);
		check("fifo full", 32'h0, {31'h0, fifo_rdy});
		check("overflow", 32'h1, {31'h0, ovf_seen});
		link_run <= 1'b1;
		// Last two strobes carry the same word, so either survivor matches
		for (int i = 0; i < 5; i++)
			expect_word(words[i < 4 ? i : 0]);
		// Power-down with pixel clock running, then with it stopped
		for (int k = 0; k < 2; k++) begin
			pd_n <= 1'b0;
			tick(12);
			check("lane oe", 32'h0, {28'h0, lane_oe, clk_oe});
			check("locked pd", 32'h0, {31'h0, locked});
			if (k == 0)
				pix_cycle(words[2], words[2]);
			pd_n <= 1'b1;
			if (k == 0)
				pix_cycle(words[3], words[3]);
			wait_lock();
			tick(2);
			check("refused rx", 32'h0, rx.rx_q.size());
			pix_cycle(words[k], words[k] ^ 21'h0FFFFF);
			expect_word(words[k]);
		end
		final_report();
	end
endmodule // testbench

bind lps_serializer lps_serializer_monitor #(.LOCK_CYCLES(LOCK_CYCLES)) mon (.CLOCK_I(CLOCK_I),
	.RESET_I(RESET_I), .LINK_CLK_I(LINK_CLK_I), .POWER_DOWN_N_I(POWER_DOWN_N_I),
	.LANE_DATA_P_O(LANE_DATA_P_O), .LANE_DATA_N_O(LANE_DATA_N_O), .LANE_DATA_OE_O(LANE_DATA_OE_O),
	.LANE_CLK_P_O(LANE_CLK_P_O), .LANE_CLK_N_O(LANE_CLK_N_O), .LANE_CLK_OE_O(LANE_CLK_OE_O),
	.LOCKED_O(LOCKED_O), .OVERFLOW_O(OVERFLOW_O));
